// >>> rtl/irq_flag_pkg.sv
// Package: register map, field positions and reset values of the interrupt block.
package irq_flag_pkg;

   // -------------------------------------------------------------------
   // Register word indices on the Avalon port
   // -------------------------------------------------------------------
   localparam logic [2:0] IDX_INTERRUPT_CONTROL = 3'h0;
   localparam logic [2:0] IDX_PERIPH_ENABLE_1   = 3'h1;
   localparam logic [2:0] IDX_PERIPH_FLAG_1     = 3'h2;
   localparam logic [2:0] IDX_TIMER0_COUNT      = 3'h3;
   localparam logic [2:0] IDX_OPTION            = 3'h4;
   localparam logic [2:0] IDX_PIN_CHANGE_MASK   = 3'h5;

   // -------------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------------
   localparam int BIT_GLOBAL_ENABLE   = 7;
   localparam int BIT_PERIPH_GROUP    = 6;
   localparam int BIT_TIMER0_ENABLE   = 5;
   localparam int BIT_EXT_PIN_ENABLE  = 4;
   localparam int BIT_PIN_CHG_ENABLE  = 3;
   localparam int BIT_TIMER0_FLAG     = 2;
   localparam int BIT_EXT_PIN_FLAG    = 1;
   localparam int BIT_PIN_CHG_FLAG    = 0;
   localparam int BIT_EXT_EDGE_SELECT = 0;
   localparam int PERIPH_SOURCES      = 6;
   localparam int CHANGE_PINS         = 8;

   // -------------------------------------------------------------------
   // Reset values and constants
   // -------------------------------------------------------------------
   localparam logic [7:0]  RST_INTERRUPT_CONTROL = 8'h00;
   localparam logic [5:0]  RST_PERIPH_ENABLE_1   = 6'h00;
   localparam logic [5:0]  RST_PERIPH_FLAG_1     = 6'h00;
   localparam logic        RST_EXT_EDGE_SELECT   = 1'b1;
   localparam logic [7:0]  RST_PIN_CHANGE_MASK   = 8'h00;
   localparam logic [7:0]  TIMER0_TOP            = 8'hff;
   localparam logic [15:0] IRQ_VECTOR_ADDR       = 16'h0004;
   localparam logic [2:0]  PRIME_CYCLES_DONE     = 3'h7;

   typedef struct packed {
      logic global_irq_enable;
      logic periph_group_enable;
      logic timer0_ovf_enable;
      logic ext_pin_irq_enable;
      logic pin_change_enable;
      logic timer0_ovf_flag;
      logic ext_pin_irq_flag;
      logic pin_change_flag;
   } interrupt_control_t;

endpackage

// >>> rtl/interrupt_enable_flag_logic.sv
// Interrupt enable and flag logic with an Avalon-MM register port.
//
// Overview of operation
// RULE1: Global enable low blocks every request; high passes enabled sources.
// RULE2: Peripheral-group enable gates all peripheral sources.
// RULE3: Peripheral request needs group enable plus its own enable.
// RULE4: Timer-0 overflow enable passes or suppresses the timer-0 interrupt.
// RULE5: Timer-0 overflow sets its flag; it stays until software clears it.
// RULE6: External pin enable passes or suppresses the external interrupt.
// RULE7: External event sets its flag, held until software clears it.
// RULE8: Pin-change enable passes or suppresses the pin-change interrupt.
// RULE9: Pin-change events need per-pin enables as well.
// RULE10: Pin-change flag sets when any enabled monitored pin changes.
// RULE11: Flags set regardless of their own or the global enable.
// RULE12: Software clears a flag before enabling its interrupt.
// RULE13: Timer-0 count survives reset; software loads it before clearing flag.
// RULE14: Bus-collision enable passes or blocks that interrupt.
// RULE15: Serial port enable passes or blocks the serial port interrupt.
// RULE16: Capture/compare 2 enable passes or blocks its interrupt.
// RULE17: Capture/compare 1 enable passes or blocks its interrupt.
// RULE18: Timer-2 enable passes or blocks the timer-2 interrupt.
// RULE19: Timer-1 enable passes or blocks the timer-1 interrupt.
// RULE20: Top two bits of peripheral enable register read zero.
// RULE21: Servicing clears global enable and presents the vector address.
// RULE22: Reset clears the global enable.
// RULE23: External flag sets on rising edge if selected, else falling.
// RULE24: Request is global enable and any enabled flagged source.
// RULE25: Each peripheral enable pairs with the same-position peripheral flag.
`timescale 1ns/1ps

module interrupt_enable_flag_logic
   import irq_flag_pkg::*;
(
   input  wire logic                                CLK_I,
   input  wire logic                                ARST_N_I,
   input  wire logic [2:0]                          AVS_ADDRESS_I,
   input  wire logic                                AVS_READ_I,
   input  wire logic                                AVS_WRITE_I,
   input  wire logic [31:0]                         AVS_WRITEDATA_I,
   input  wire logic [3:0]                          AVS_BYTEENABLE_I,
   output logic      [31:0]                         AVS_READDATA_O,
   output logic                                     AVS_WAITREQUEST_O,
   input  wire logic                                TIMER0_TICK_I,
   input  wire logic                                EXT_IRQ_PIN_I,
   input  wire logic [irq_flag_pkg::CHANGE_PINS-1:0]    CHANGE_PINS_I,
   input  wire logic [irq_flag_pkg::PERIPH_SOURCES-1:0] PERIPH_EVENT_I,
   input  wire logic                                IRQ_ACK_I,
   input  wire logic                                IRQ_RETURN_I,
   output logic                                     IRQ_O,
   output logic      [15:0]                         VECTOR_O
);

   import irq_flag_pkg::*;

   // -------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------
   interrupt_control_t              ctrl;
   logic [PERIPH_SOURCES-1:0]       periph_enable;
   logic [PERIPH_SOURCES-1:0]       periph_flag;
   logic [7:0]                      timer0_count;
   logic                            ext_edge_select;
   logic [CHANGE_PINS-1:0]          per_pin_change_enables;
   logic                            ack;
   logic                            wr_fire;
   logic                            we_ctrl;
   logic                            we_pen;
   logic                            we_pflag;
   logic                            we_timer;
   logic                            we_option;
   logic                            we_mask;
   logic [7:0]                      wdata;
   logic [7:0]                      rd_value;
   logic                            ext_sync1;
   logic                            ext_sync2;
   logic                            ext_prev;
   logic [CHANGE_PINS-1:0]          chg_sync1;
   logic [CHANGE_PINS-1:0]          chg_sync2;
   logic [CHANGE_PINS-1:0]          chg_prev;
   logic [2:0]                      prime;
   logic                            primed;
   logic                            timer0_ovf;
   logic                            ext_event;
   logic                            chg_event;
   logic                            core_req;
   logic                            periph_req;
   logic [PERIPH_SOURCES-1:0]       next_periph_flag;

   function automatic logic hit(input logic [2:0] addr, input logic [2:0] idx);
      return addr == idx;
   endfunction

   // -------------------------------------------------------------------
   // Avalon-MM slave: one wait state, registered read data
   // -------------------------------------------------------------------
   assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack;
   assign wr_fire           = AVS_WRITE_I & ack & AVS_BYTEENABLE_I[0];
   assign wdata             = AVS_WRITEDATA_I[7:0];
   assign we_ctrl           = wr_fire & hit(AVS_ADDRESS_I, IDX_INTERRUPT_CONTROL);
   assign we_pen            = wr_fire & hit(AVS_ADDRESS_I, IDX_PERIPH_ENABLE_1);
   assign we_pflag          = wr_fire & hit(AVS_ADDRESS_I, IDX_PERIPH_FLAG_1);
   assign we_timer          = wr_fire & hit(AVS_ADDRESS_I, IDX_TIMER0_COUNT);
   assign we_option         = wr_fire & hit(AVS_ADDRESS_I, IDX_OPTION);
   assign we_mask           = wr_fire & hit(AVS_ADDRESS_I, IDX_PIN_CHANGE_MASK);

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         ack <= 1'b0;
      end else begin
         ack <= (AVS_READ_I | AVS_WRITE_I) & ~ack;
      end
   end

   always_comb begin
      rd_value = 8'h00;
      if (hit(AVS_ADDRESS_I, IDX_INTERRUPT_CONTROL)) begin
         rd_value = ctrl;
      end
      // RULE20: unimplemented bits zero
      if (hit(AVS_ADDRESS_I, IDX_PERIPH_ENABLE_1)) begin
         rd_value = {2'b00, periph_enable};
      end
      if (hit(AVS_ADDRESS_I, IDX_PERIPH_FLAG_1)) begin
         rd_value = {2'b00, periph_flag};
      end
      if (hit(AVS_ADDRESS_I, IDX_TIMER0_COUNT)) begin
         rd_value = timer0_count;
      end
      if (hit(AVS_ADDRESS_I, IDX_OPTION)) begin
         rd_value = {7'h00, ext_edge_select};
      end
      if (hit(AVS_ADDRESS_I, IDX_PIN_CHANGE_MASK)) begin
         rd_value = per_pin_change_enables;
      end
   end

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         AVS_READDATA_O <= 32'h0000_0000;
      end else if (AVS_READ_I && !ack) begin
         AVS_READDATA_O <= {24'h00_0000, rd_value};
      end
   end

   // -------------------------------------------------------------------
   // Pin synchronisers and edge detection
   // -------------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         ext_sync1 <= 1'b0;
         ext_sync2 <= 1'b0;
         ext_prev  <= 1'b0;
         chg_sync1 <= '0;
         chg_sync2 <= '0;
         chg_prev  <= '0;
      end else begin
         ext_sync1 <= EXT_IRQ_PIN_I;
         ext_sync2 <= ext_sync1;
         ext_prev  <= ext_sync2;
         chg_sync1 <= CHANGE_PINS_I;
         chg_sync2 <= chg_sync1;
         chg_prev  <= chg_sync2;
      end
   end

   // Edges are ignored until the synchronisers hold real pin levels.
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         prime <= 3'h0;
      end else if (!primed) begin
         prime <= prime + 3'h1;
      end
   end
   assign primed = (prime == PRIME_CYCLES_DONE);

   // RULE23: edge polarity by select bit
   assign ext_event = primed & (ext_edge_select ? (ext_sync2 & ~ext_prev)
                                                : (~ext_sync2 & ext_prev));
   // RULE9: only enabled pins count
   assign chg_event = primed & (|((chg_sync2 ^ chg_prev) & per_pin_change_enables));

   // -------------------------------------------------------------------
   // Timer-0 count
   // -------------------------------------------------------------------
   // RULE13: count has no reset
   always_ff @(posedge CLK_I) begin
      if (we_timer) begin
         timer0_count <= wdata;
      end else if (TIMER0_TICK_I) begin
         timer0_count <= timer0_count + 8'h01;
      end
   end
   assign timer0_ovf = TIMER0_TICK_I & ~we_timer & (timer0_count == TIMER0_TOP);

   // -------------------------------------------------------------------
   // Configuration registers
   // -------------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         ext_edge_select        <= RST_EXT_EDGE_SELECT;
         per_pin_change_enables <= RST_PIN_CHANGE_MASK;
      end else begin
         if (we_option) begin
            ext_edge_select <= wdata[BIT_EXT_EDGE_SELECT];
         end
         if (we_mask) begin
            per_pin_change_enables <= wdata;
         end
      end
   end

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         periph_enable <= RST_PERIPH_ENABLE_1;
      end else if (we_pen) begin
         periph_enable <= wdata[PERIPH_SOURCES-1:0];
      end
   end

   // -------------------------------------------------------------------
   // Interrupt control: enables and global enable
   // -------------------------------------------------------------------
   // RULE22: reset clears global enable
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         ctrl.global_irq_enable <= RST_INTERRUPT_CONTROL[BIT_GLOBAL_ENABLE];
      // RULE21: service clears global enable
      end else if (IRQ_ACK_I) begin
         ctrl.global_irq_enable <= 1'b0;
      end else if (IRQ_RETURN_I) begin
         ctrl.global_irq_enable <= 1'b1;
      end else if (we_ctrl) begin
         ctrl.global_irq_enable <= wdata[BIT_GLOBAL_ENABLE];
      end
   end

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         ctrl.periph_group_enable <= RST_INTERRUPT_CONTROL[BIT_PERIPH_GROUP];
         ctrl.timer0_ovf_enable   <= RST_INTERRUPT_CONTROL[BIT_TIMER0_ENABLE];
         ctrl.ext_pin_irq_enable  <= RST_INTERRUPT_CONTROL[BIT_EXT_PIN_ENABLE];
         ctrl.pin_change_enable   <= RST_INTERRUPT_CONTROL[BIT_PIN_CHG_ENABLE];
      end else if (we_ctrl) begin
         ctrl.periph_group_enable <= wdata[BIT_PERIPH_GROUP];
         ctrl.timer0_ovf_enable   <= wdata[BIT_TIMER0_ENABLE];
         ctrl.ext_pin_irq_enable  <= wdata[BIT_EXT_PIN_ENABLE];
         ctrl.pin_change_enable   <= wdata[BIT_PIN_CHG_ENABLE];
      end
   end

   // -------------------------------------------------------------------
   // Sticky flags: an event in the clearing cycle wins
   // -------------------------------------------------------------------
   // RULE5: timer-0 flag set and hold
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         ctrl.timer0_ovf_flag  <= RST_INTERRUPT_CONTROL[BIT_TIMER0_FLAG];
         ctrl.ext_pin_irq_flag <= RST_INTERRUPT_CONTROL[BIT_EXT_PIN_FLAG];
         ctrl.pin_change_flag  <= RST_INTERRUPT_CONTROL[BIT_PIN_CHG_FLAG];
      end else begin
         // RULE11: set ignores enables
         ctrl.timer0_ovf_flag  <= (we_ctrl ? wdata[BIT_TIMER0_FLAG]
                                           : ctrl.timer0_ovf_flag) | timer0_ovf;
         // RULE7: external flag held
         ctrl.ext_pin_irq_flag <= (we_ctrl ? wdata[BIT_EXT_PIN_FLAG]
                                           : ctrl.ext_pin_irq_flag) | ext_event;
         // RULE10: pin-change flag set
         ctrl.pin_change_flag  <= (we_ctrl ? wdata[BIT_PIN_CHG_FLAG]
                                           : ctrl.pin_change_flag) | chg_event;
      end
   end

   genvar g;
   generate
      for (g = 0; g < PERIPH_SOURCES; g++) begin : g_pflag
         assign next_periph_flag[g] = (we_pflag ? wdata[g] : periph_flag[g])
                                      | PERIPH_EVENT_I[g];
      end
   endgenerate

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         periph_flag <= RST_PERIPH_FLAG_1;
      end else begin
         periph_flag <= next_periph_flag;
      end
   end

   // -------------------------------------------------------------------
   // Request to the core
   // -------------------------------------------------------------------
   // RULE4: timer-0 pair
   // RULE6: external pin pair
   // RULE8: pin-change pair
   assign core_req = (ctrl.timer0_ovf_enable  & ctrl.timer0_ovf_flag)
                   | (ctrl.ext_pin_irq_enable & ctrl.ext_pin_irq_flag)
                   | (ctrl.pin_change_enable  & ctrl.pin_change_flag);
   // RULE25: position-wise pairing
   // RULE14: bit 5 collision source
   // RULE15: bit 4 serial source
   // RULE16: bit 3 capcmp2 source
   // RULE17: bit 2 capcmp1 source
   // RULE18: bit 1 timer-2 source
   // RULE19: bit 0 timer-1 source
   // RULE2: group enable gate
   // RULE3: both enables needed
   assign periph_req = ctrl.periph_group_enable & (|(periph_enable & periph_flag));
   // RULE1: global gate
   // RULE24: combined request
   assign IRQ_O = ctrl.global_irq_enable & (core_req | periph_req);

   // RULE21: vector address for the core
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         VECTOR_O <= IRQ_VECTOR_ADDR;
      end else begin
         VECTOR_O <= IRQ_VECTOR_ADDR;
      end
   end

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   a_global_gate_off: // RULE1
   assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      !ctrl.global_irq_enable |-> !IRQ_O)
      else $error("request raised with global enable low");

   a_periph_group_gate: // RULE2
   assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      (!ctrl.periph_group_enable && !core_req) |-> !IRQ_O)
      else $error("peripheral request passed with group enable low");

   a_periph_pair_req: // RULE3
   assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      (ctrl.global_irq_enable && ctrl.periph_group_enable
       && |(periph_enable & periph_flag)) |-> IRQ_O)
      else $error("enabled peripheral source did not request");

   a_timer0_pair_req: // RULE4
   assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      (ctrl.global_irq_enable && ctrl.timer0_ovf_enable && ctrl.timer0_ovf_flag)
      |-> IRQ_O)
      else $error("timer-0 source did not request");

   a_timer0_flag_set: // RULE5
   assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      (TIMER0_TICK_I && !we_timer && timer0_count == 8'hff)
      |=> ctrl.timer0_ovf_flag && timer0_count == 8'h00)
      else $error("timer-0 overflow did not set flag");

   a_timer0_flag_hold: // RULE5
   assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      (ctrl.timer0_ovf_flag && !we_ctrl) |=> ctrl.timer0_ovf_flag)
      else $error("timer-0 flag dropped without a write");

   a_ext_pair_req: // RULE6
   assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      (ctrl.global_irq_enable && ctrl.ext_pin_irq_enable && ctrl.ext_pin_irq_flag)
      |-> IRQ_O)
      else $error("external source did not request");

   a_ext_edge_flag: // RULE23
   assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      (primed && ext_edge_select && ext_sync2 && !ext_prev) |=> ctrl.ext_pin_irq_flag)
      else $error("rising edge missed on external pin");

   a_chg_masked_pins: // RULE9
   assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      (!ctrl.pin_change_flag && !we_ctrl
       && ((chg_sync2 ^ chg_prev) & per_pin_change_enables) == '0)
      |=> !ctrl.pin_change_flag)
      else $error("pin-change flag set by a masked pin");

   a_chg_flag_set: // RULE10
   assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      (primed && |((chg_sync2 ^ chg_prev) & per_pin_change_enables))
      |=> ctrl.pin_change_flag)
      else $error("enabled pin change did not set flag");

   a_flag_no_enable: // RULE11
   assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      PERIPH_EVENT_I[0] |=> periph_flag[0])
      else $error("peripheral flag not set by its event");

   a_pen_top_zero: // RULE20
   assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      (AVS_READ_I && !ack && AVS_ADDRESS_I == IDX_PERIPH_ENABLE_1)
      |=> AVS_READDATA_O[7:6] == 2'b00 && !AVS_WAITREQUEST_O)
      else $error("peripheral enable top bits not zero");

   a_service_clears_gie: // RULE21
   assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      IRQ_ACK_I |=> !ctrl.global_irq_enable && !IRQ_O)
      else $error("service did not clear global enable");

endmodule

// >>> tb/core_model.sv
// Behavioural processor core that takes an interrupt and returns from it.
`timescale 1ns/1ps

module core_model (
   input  wire logic       clk_i,
   input  wire logic       arst_n_i,
   input  wire logic       irq_i,
   input  wire logic       take_i,
   input  wire logic [7:0] ret_delay_i,
   output logic            ack_o,
   output logic            ret_o
);
   logic       armed;
   logic [7:0] wait_cnt;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         armed <= 1'b0;
         ack_o <= 1'b0;
         ret_o <= 1'b0;
         wait_cnt <= 8'h00;
      end else begin
         ack_o <= 1'b0;
         ret_o <= 1'b0;
         if (take_i) begin
            armed <= 1'b1;
         end
         if (armed && irq_i) begin
            ack_o <= 1'b1;
            armed <= 1'b0;
            wait_cnt <= ret_delay_i;
         end else if (wait_cnt != 8'h00) begin
            wait_cnt <= wait_cnt - 8'h01;
            ret_o <= (wait_cnt == 8'h01);
         end
      end
   end
endmodule

// >>> tb/test_interrupt_enable_flag_logic.sv
// Self-checking bench for the interrupt enable and flag block.
`timescale 1ns/1ps

module test_interrupt_enable_flag_logic;
   import irq_flag_pkg::*;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic        tick = 1'b0;
   logic        ext_pin = 1'b0;
   logic        take = 1'b0;
   logic [2:0]  addr = 3'h0;
   logic [31:0] wdata = 32'h0;
   logic [7:0]  pins = 8'h00;
   logic [7:0]  ret_delay = 8'h02;
   logic [5:0]  ev = 6'h00;
   logic [31:0] rdata, r;
   logic        waitreq, ack, ret, irq;
   logic [15:0] vec;
   logic [7:0]  q;
   int          errors = 0;
   int          comparisons = 0;
   int          ctrl = 0;
   int          pen = 0;
   int          pfl = 0;
   int          n;
   int          dly[2] = '{2, 40};

   interrupt_enable_flag_logic DUT (.CLK_I(clk), .ARST_N_I(arst_n), .AVS_ADDRESS_I(addr),
      .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hf),
      .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .TIMER0_TICK_I(tick),
      .EXT_IRQ_PIN_I(ext_pin), .CHANGE_PINS_I(pins), .PERIPH_EVENT_I(ev), .IRQ_ACK_I(ack),
      .IRQ_RETURN_I(ret), .IRQ_O(irq), .VECTOR_O(vec));
   core_model core (.clk_i(clk), .arst_n_i(arst_n), .irq_i(irq), .take_i(take),
      .ret_delay_i(ret_delay), .ack_o(ack), .ret_o(ret));

   initial begin
      forever #5 clk = ~clk;
   end

   // -------------------------------------------------------------------
   // Checking and bus tasks
   // -------------------------------------------------------------------
   task automatic final_report();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
      n = 0;
      @(posedge clk);
      rd <= ~w;
      wr <= w;
      addr <= a;
      wdata <= {24'h0, d};
      // The request stands until the rising edge that samples waitrequest low.
      do begin
         @(posedge clk);
         n++;
      end while (waitreq !== 1'b0 && n < 20);
      if (n >= 20) begin
         errors++;
         final_report();
      end
      q = rdata[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic rdreg(input logic [2:0] a, input logic [7:0] exp, input string name);
      bus(1'b0, a, 8'h00);
      check(name, {24'h0, q}, {24'h0, exp});
   endtask

   function automatic logic exp_irq();
      return ctrl[7] & ((ctrl[5] & ctrl[2]) | (ctrl[4] & ctrl[1]) | (ctrl[3] & ctrl[0])
                        | (ctrl[6] & |(pen & pfl)));
   endfunction

   task automatic chk_all();
      rdreg(IDX_INTERRUPT_CONTROL, ctrl[7:0], "control");
      rdreg(IDX_PERIPH_ENABLE_1, pen[7:0], "periph_enable");
      rdreg(IDX_PERIPH_FLAG_1, pfl[7:0], "periph_flag");
      @(negedge clk);
      check("irq", {31'h0, irq}, {31'h0, exp_irq()});
   endtask

   task automatic pulse(input logic [5:0] e);
      @(posedge clk);
      ev <= e;
      @(posedge clk);
      ev <= 6'h00;
      pfl = pfl | e;
   endtask

   task automatic settle();
      repeat (6) @(posedge clk);
   endtask

   // -------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------
   initial begin
      void'($urandom(16034));
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      chk_all();
      rdreg(IDX_OPTION, 8'h01, "option");
      bus(1'b1, 3'h6, 8'hff);
      rdreg(3'h6, 8'h00, "unmapped");
      bus(1'b1, IDX_INTERRUPT_CONTROL, 8'hc0);
      ctrl = 'hc0;
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, IDX_PERIPH_ENABLE_1, 8'hc0 | (8'h01 << i));
         pen = 1 << i;
         pulse(6'h3f ^ (6'h01 << i));
         chk_all();
         pulse(6'h01 << i);
         chk_all();
         bus(1'b1, IDX_PERIPH_FLAG_1, 8'h00);
         pfl = 0;
      end
      for (int i = 0; i < 8; i++) begin
         r = $urandom;
         bus(1'b1, IDX_PERIPH_ENABLE_1, r[7:0]);
         pen = r[5:0];
         bus(1'b1, IDX_INTERRUPT_CONTROL, r[15:8] & 8'hf8);
         ctrl = r[15:8] & 'hf8;
         pulse(r[21:16]);
         chk_all();
         bus(1'b1, IDX_PERIPH_FLAG_1, 8'h00);
         pfl = 0;
      end
      pen = 0;
      bus(1'b1, IDX_PERIPH_ENABLE_1, 8'h00);
      bus(1'b1, IDX_INTERRUPT_CONTROL, 8'ha0);
      ctrl = 'ha0;
      bus(1'b1, IDX_TIMER0_COUNT, 8'hfe);
      repeat (2) begin
         @(posedge clk);
         tick <= 1'b1;
         @(posedge clk);
         tick <= 1'b0;
      end
      ctrl = 'ha4;
      chk_all();
      rdreg(IDX_TIMER0_COUNT, 8'h00, "timer0_count");
      bus(1'b1, IDX_INTERRUPT_CONTROL, 8'h84);
      ctrl = 'h84;
      chk_all();
      bus(1'b1, IDX_TIMER0_COUNT, 8'h5a);
      @(posedge clk);
      arst_n <= 1'b0;
      @(posedge clk);
      arst_n <= 1'b1;
      ctrl = 0;
      chk_all();
      rdreg(IDX_TIMER0_COUNT, 8'h5a, "timer0_kept");
      bus(1'b1, IDX_INTERRUPT_CONTROL, 8'h90);
      ext_pin <= 1'b1;
      settle();
      ctrl = 'h92;
      chk_all();
      bus(1'b1, IDX_INTERRUPT_CONTROL, 8'h80);
      bus(1'b1, IDX_OPTION, 8'h00);
      ext_pin <= 1'b0;
      settle();
      ctrl = 'h82;
      chk_all();
      bus(1'b1, IDX_INTERRUPT_CONTROL, 8'h88);
      pins <= 8'h08;
      settle();
      ctrl = 'h88;
      chk_all();
      bus(1'b1, IDX_PIN_CHANGE_MASK, 8'h08);
      pins <= 8'h00;
      settle();
      ctrl = 'h89;
      chk_all();
      foreach (dly[k]) begin
         ret_delay <= dly[k][7:0];
         bus(1'b1, IDX_INTERRUPT_CONTROL, 8'h92);
         ctrl = 'h92;
         @(posedge clk);
         take <= 1'b1;
         @(posedge clk);
         take <= 1'b0;
         n = 0;
         while (irq !== 1'b0 && n < 20) begin
            @(posedge clk);
            n++;
         end
         check("ack_wait", n < 20, 1);
         if (n >= 20) begin
            final_report();
         end
         repeat (10) @(posedge clk);
         ctrl = (dly[k] < 10) ? 'h92 : 'h12;
         chk_all();
         check("vector", {16'h0, vec}, {16'h0, IRQ_VECTOR_ADDR});
         repeat (40) @(posedge clk);
      end
      final_report();
   end
endmodule
